// [src/ucd_decoder.sv]
// Command decoder that interprets processor command bytes and runs the data phases.
`timescale 1ns/1ps
module ucd_decoder
   import ucd_pkg::*;
#(
   parameter int BUS16 = 1
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              srst,
   // Processor bus access, same clock domain
   input  wire ucd_bus_t          bus_in,
   output logic [15:0]            rd_data,
   // Endpoint side
   input  wire logic [NUM_EP-1:0] ep_iso,
   input  wire logic [7:0]        ep_status     [NUM_EP],
   input  wire logic [7:0]        ep_error      [NUM_EP],
   input  wire logic [15:0]       frame_number,
   input  wire logic [15:0]       buf_rd_data,
   output ucd_ep_cmd_t            ep_cmd,
   output logic                   buf_wr,
   output logic                   buf_rd,
   output logic [3:0]             buf_ep,
   output logic [15:0]            buf_wr_data,
   // Register values and device reset
   output logic [31:0]            irq_enable_reg,
   output logic [15:0]            dma_setup_reg,
   output logic [15:0]            dma_count_reg,
   output logic [15:0]            scratch_reg,
   output logic                   unlocked,
   output logic                   dev_reset
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (BUS16 != 0 && BUS16 != 1) begin : g_chk
      $error("BUS16 must be 0 or 1");
   end

   localparam logic [10:0] STEP = (BUS16 != 0) ? 11'h002 : 11'h001;

   ucd_tgt_t    tgt_reg;
   logic [10:0] len_reg;
   logic [10:0] idx_reg;
   logic [3:0]  ep_reg;
   logic [31:0] shadow_reg;
   logic        cmd_stb;
   logic        dat_stb;
   logic        phase_live;
   logic [7:0]  code;
   logic [10:0] idx_next;
   logic        last_beat;

   assign code       = bus_in.data[7:0];
   assign cmd_stb    = bus_in.strobe & bus_in.select;
   assign dat_stb    = bus_in.strobe & ~bus_in.select;
   assign phase_live = (tgt_reg != TGT_NONE) && (idx_reg < len_reg);
   assign idx_next   = idx_reg + STEP;
   assign last_beat  = dat_stb && phase_live && (idx_next >= len_reg);

   // ****************************************************************
   // Command decode: target, length and endpoint.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         tgt_reg <= TGT_NONE;
         len_reg <= '0;
         ep_reg  <= '0;
      end else if (cmd_stb) begin
         ep_reg  <= code[3:0];
         tgt_reg <= TGT_NONE;
         len_reg <= '0;
         unique case (code)
            CMD_IRQ_EN_WR, CMD_IRQ_EN_RD: begin
               tgt_reg <= TGT_IRQ_EN;
               len_reg <= LEN_IRQ_EN;
            end
            CMD_DMA_SET_WR, CMD_DMA_SET_RD: begin
               tgt_reg <= TGT_DMA_SET;
               len_reg <= LEN_TWO;
            end
            CMD_DMA_CNT_WR, CMD_DMA_CNT_RD: begin
               tgt_reg <= TGT_DMA_CNT;
               len_reg <= LEN_TWO;
            end
            CMD_UNLOCK: begin
               tgt_reg <= TGT_UNLOCK;
               len_reg <= LEN_TWO;
            end
            CMD_SCRATCH_WR, CMD_SCRATCH_RD: begin
               tgt_reg <= TGT_SCRATCH;
               len_reg <= LEN_TWO;
            end
            CMD_FRAME_RD: begin
               tgt_reg <= TGT_FRAME;
               len_reg <= LEN_TWO;
            end
            default: begin
               unique case (code[7:4])
                  GRP_BUF_WR: begin
                     if (code[3:0] != 4'h0) begin
                        tgt_reg <= TGT_BUF_WR;
                        len_reg <= (code[3:0] == 4'h1) ? LEN_CTRL_BUF :
                                   (ep_iso[code[3:0]] ? LEN_ISO_BUF : LEN_BULK_BUF);
                     end
                  end
                  GRP_BUF_RD: begin
                     if (code[3:0] != 4'h1) begin
                        tgt_reg <= TGT_BUF_RD;
                        len_reg <= (code[3:0] == 4'h0) ? LEN_CTRL_BUF :
                                   (ep_iso[code[3:0]] ? LEN_ISO_BUF : LEN_BULK_BUF);
                     end
                  end
                  GRP_STATUS, GRP_STAT_COPY: begin
                     tgt_reg <= TGT_STATUS;
                     len_reg <= LEN_ONE;
                  end
                  GRP_ERROR: begin
                     tgt_reg <= TGT_ERROR;
                     len_reg <= LEN_ONE;
                  end
                  default: begin
                     tgt_reg <= TGT_NONE;
                  end
               endcase
            end
         endcase
      end else if (last_beat) begin
         tgt_reg <= TGT_NONE;
      end
   end

   // ****************************************************************
   // Byte index through the data phase.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (srst || cmd_stb) begin
         idx_reg <= '0;
      end else if (dat_stb && phase_live) begin
         idx_reg <= idx_next;
      end
   end

   // ****************************************************************
   // Immediate commands without data phase, plus the status_rd pulse of status reads.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         ep_cmd    <= '0;
         dev_reset <= 1'b0;
      end else begin
         ep_cmd           <= '0;
         dev_reset        <= cmd_stb && (code == CMD_DEV_RESET);
         ep_cmd.ep        <= code[3:0];
         if (cmd_stb) begin
            ep_cmd.stall     <= (code[7:4] == GRP_STALL);
            ep_cmd.unstall   <= (code[7:4] == GRP_UNSTALL);
            ep_cmd.validate  <= (code[7:4] == GRP_VALIDATE) && (code[3:0] != 4'h0);
            ep_cmd.clear     <= (code[7:4] == GRP_CLEAR) && (code[3:0] != 4'h1);
            ep_cmd.setup_ack <= (code == CMD_SETUP_ACK);
            ep_cmd.status_rd <= (code[7:4] == GRP_STATUS);
         end
      end
   end

   // ****************************************************************
   // Registers written through the data phase, least significant first.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (srst || dev_reset) begin
         irq_enable_reg <= RST_IRQ_EN;
         dma_setup_reg  <= RST_WORD;
         dma_count_reg  <= RST_WORD;
         scratch_reg    <= RST_WORD;
         shadow_reg     <= RST_IRQ_EN;
      end else if (dat_stb && phase_live && bus_in.write) begin
         if (BUS16 != 0) begin
            shadow_reg[idx_reg[1:0]*8 +: 16] <= bus_in.data;
         end else begin
            shadow_reg[idx_reg[1:0]*8 +: 8] <= bus_in.data[7:0];
         end
         if (last_beat) begin
            unique case (tgt_reg)
               TGT_IRQ_EN:  irq_enable_reg <= (BUS16 != 0) ? {bus_in.data, shadow_reg[15:0]}
                                                           : {bus_in.data[7:0], shadow_reg[23:0]};
               TGT_DMA_SET: dma_setup_reg  <= (BUS16 != 0) ? bus_in.data : {bus_in.data[7:0], shadow_reg[7:0]};
               TGT_DMA_CNT: dma_count_reg  <= (BUS16 != 0) ? bus_in.data : {bus_in.data[7:0], shadow_reg[7:0]};
               TGT_SCRATCH: scratch_reg    <= (BUS16 != 0) ? bus_in.data : {bus_in.data[7:0], shadow_reg[7:0]};
               default:     scratch_reg    <= scratch_reg;
            endcase
         end
      end
   end

   // Unlock flag, set after the two unlock bytes; cleared by reset.
   always_ff @(posedge mclk) begin
      if (srst || dev_reset) begin
         unlocked <= 1'b0;
      end else if (last_beat && bus_in.write && tgt_reg == TGT_UNLOCK) begin
         unlocked <= 1'b1;
      end
   end

   // ****************************************************************
   // Buffer access strobes.
   // ****************************************************************
   assign buf_wr      = dat_stb && phase_live && bus_in.write && (tgt_reg == TGT_BUF_WR);
   assign buf_rd      = dat_stb && phase_live && !bus_in.write && (tgt_reg == TGT_BUF_RD);
   assign buf_ep      = ep_reg;
   assign buf_wr_data = bus_in.data;

   // ****************************************************************
   // Read data selected combinationally from the current target and index.
   // ****************************************************************
   always_comb begin
      logic [31:0] src;
      src = '0;
      unique case (tgt_reg)
         TGT_IRQ_EN:  src = irq_enable_reg;
         TGT_DMA_SET: src = {16'h0000, dma_setup_reg};
         TGT_DMA_CNT: src = {16'h0000, dma_count_reg};
         TGT_SCRATCH: src = {16'h0000, scratch_reg};
         TGT_FRAME:   src = {16'h0000, frame_number};
         TGT_BUF_RD:  src = {16'h0000, buf_rd_data};
         TGT_STATUS:  src = {24'h000000, ep_status[ep_reg]};
         TGT_ERROR:   src = {24'h000000, ep_error[ep_reg]};
         default:     src = '0;
      endcase
      if (tgt_reg == TGT_BUF_RD) begin
         rd_data = (BUS16 != 0) ? src[15:0] : {8'h00, src[7:0]};
      end else if (tgt_reg == TGT_STATUS || tgt_reg == TGT_ERROR) begin
         rd_data = {8'h00, src[7:0]};
      end else begin
         rd_data = (BUS16 != 0) ? src[idx_reg[1:0]*8 +: 16] : {8'h00, src[idx_reg[1:0]*8 +: 8]};
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_reset_cmd;
      @(posedge mclk) disable iff (srst) (cmd_stb && code == CMD_DEV_RESET) |=> dev_reset ##1 (irq_enable_reg == '0);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("device reset not applied");

   property p_stall;
      @(posedge mclk) disable iff (srst) (cmd_stb && code[7:4] == GRP_STALL) |=> ep_cmd.stall && ep_cmd.ep == $past(code[3:0]);
   endproperty
   a_stall: assert property (p_stall) else $error("stall not issued");

   property p_unstall;
      @(posedge mclk) disable iff (srst) (cmd_stb && code[7:4] == GRP_UNSTALL) |=> ep_cmd.unstall && !ep_cmd.stall;
   endproperty
   a_unstall: assert property (p_unstall) else $error("unstall not issued");

   property p_validate_out;
      @(posedge mclk) disable iff (srst) (cmd_stb && code == 8'h60) |=> !ep_cmd.validate;
   endproperty
   a_validate_out: assert property (p_validate_out) else $error("OUT buffer validated");

   property p_clear_in;
      @(posedge mclk) disable iff (srst) (cmd_stb && code == 8'h71) |=> !ep_cmd.clear;
   endproperty
   a_clear_in: assert property (p_clear_in) else $error("IN buffer cleared");

   property p_setup_ack;
      @(posedge mclk) disable iff (srst) (cmd_stb && code == CMD_SETUP_ACK) |=> ep_cmd.setup_ack ##1 !ep_cmd.setup_ack;
   endproperty
   a_setup_ack: assert property (p_setup_ack) else $error("setup ack not one pulse");

   property p_copy_quiet;
      @(posedge mclk) disable iff (srst) (cmd_stb && code[7:4] == GRP_STAT_COPY) |=> !ep_cmd.status_rd;
   endproperty
   a_copy_quiet: assert property (p_copy_quiet) else $error("status copy disturbed status");

   property p_irq_len;
      @(posedge mclk) disable iff (srst) (cmd_stb && code == CMD_IRQ_EN_WR) |=> (tgt_reg == TGT_IRQ_EN && len_reg == 11'h004);
   endproperty
   a_irq_len: assert property (p_irq_len) else $error("irq enable length wrong");

   property p_scratch;
      @(posedge mclk) disable iff (srst)
         (BUS16 != 0 && dat_stb && bus_in.write && tgt_reg == TGT_SCRATCH && idx_reg == '0)
         |=> (scratch_reg == $past(bus_in.data)) && (tgt_reg == TGT_NONE);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch word not stored");

   property p_byte_upper;
      @(posedge mclk) disable iff (srst) (tgt_reg == TGT_STATUS || tgt_reg == TGT_ERROR) |-> rd_data[15:8] == 8'h00;
   endproperty
   a_byte_upper: assert property (p_byte_upper) else $error("upper byte not zero");

   c_buf_wr:  cover property (@(posedge mclk) disable iff (srst) buf_wr ##1 buf_wr);
   c_reset:   cover property (@(posedge mclk) disable iff (srst) dev_reset);
   c_unlock:  cover property (@(posedge mclk) disable iff (srst) $rose(unlocked));
   c_status:  cover property (@(posedge mclk) disable iff (srst) tgt_reg == TGT_STATUS ##1 dat_stb);

endmodule // ucd_decoder

// [src/ucd_pkg.sv]
// Package of constants and carrier types for the peripheral command decoder.
// Operation
// - C2 writes, C3 reads interrupt enable register, four data bytes each.
// - F0 writes, F1 reads DMA setup register, two data bytes each.
// - F2 writes, F3 reads DMA count register, two data bytes each.
// - F6 resets all controller registers at once, no data phase.
// - Code 01 loads up to 64 bytes into control IN buffer; 00 illegal.
// - Codes 02-0F write IN endpoint buffers; isochronous 1023, others 64 bytes.
// - Code 10 reads up to 64 bytes of control OUT; 11 illegal.
// - Codes 12-1F read OUT endpoint buffers; isochronous 1023, others 64 bytes.
// - Codes 40-4F stall control and endpoints 2-15; no data phase.
// - Codes 80-8F remove stall from control and endpoints; no data phase.
// - Codes 50-5F return one status byte per endpoint.
// - Codes 61-6F validate IN buffers; never validate OUT buffers.
// - Codes 70, 72-7F clear OUT buffers; never clear IN buffers.
// - Codes D0-DF return status copy without changing status or interrupt bits.
// - F4 acknowledges setup on both control directions, no data phase.
// - Codes A0-AF return one error code byte per endpoint.
// - Unlock takes two written bytes and restores register write access; the decoder only sets unlocked and never blocks writes.
// - B2 writes, B3 reads two-byte scratch register without side effects.
// - B4 returns frame number; one or two bytes may be read.
// - On 16-bit bus N bytes take (N+1)/2 word accesses.
// - For 8-bit registers on 16-bit bus the upper byte is invalid.
// - Select high takes low byte as command; no-data commands run at once.
// - Select low moves data; least significant byte or word first.
package ucd_pkg;

   // ****************************************************************
   // Command codes
   // ****************************************************************
   localparam logic [7:0] CMD_IRQ_EN_WR  = 8'hc2;
   localparam logic [7:0] CMD_IRQ_EN_RD  = 8'hc3;
   localparam logic [7:0] CMD_DMA_SET_WR = 8'hf0;
   localparam logic [7:0] CMD_DMA_SET_RD = 8'hf1;
   localparam logic [7:0] CMD_DMA_CNT_WR = 8'hf2;
   localparam logic [7:0] CMD_DMA_CNT_RD = 8'hf3;
   localparam logic [7:0] CMD_SETUP_ACK  = 8'hf4;
   localparam logic [7:0] CMD_DEV_RESET  = 8'hf6;
   localparam logic [7:0] CMD_UNLOCK     = 8'hb0;
   localparam logic [7:0] CMD_SCRATCH_WR = 8'hb2;
   localparam logic [7:0] CMD_SCRATCH_RD = 8'hb3;
   localparam logic [7:0] CMD_FRAME_RD   = 8'hb4;
   localparam logic [3:0] GRP_BUF_WR     = 4'h0;
   localparam logic [3:0] GRP_BUF_RD     = 4'h1;
   localparam logic [3:0] GRP_STALL      = 4'h4;
   localparam logic [3:0] GRP_STATUS     = 4'h5;
   localparam logic [3:0] GRP_VALIDATE   = 4'h6;
   localparam logic [3:0] GRP_CLEAR      = 4'h7;
   localparam logic [3:0] GRP_UNSTALL    = 4'h8;
   localparam logic [3:0] GRP_ERROR      = 4'ha;
   localparam logic [3:0] GRP_STAT_COPY  = 4'hd;

   // ****************************************************************
   // Lengths and reset values
   // ****************************************************************
   localparam logic [10:0] LEN_CTRL_BUF  = 11'h040;
   localparam logic [10:0] LEN_ISO_BUF   = 11'h3ff;
   localparam logic [10:0] LEN_BULK_BUF  = 11'h040;
   localparam logic [10:0] LEN_IRQ_EN    = 11'h004;
   localparam logic [10:0] LEN_TWO       = 11'h002;
   localparam logic [10:0] LEN_ONE       = 11'h001;
   localparam logic [31:0] RST_IRQ_EN    = 32'h0000_0000;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam int          NUM_EP        = 16;

   // Kind of target selected by the last command byte.
   typedef enum logic [3:0] {
      TGT_NONE, TGT_IRQ_EN, TGT_DMA_SET, TGT_DMA_CNT, TGT_UNLOCK, TGT_SCRATCH,
      TGT_FRAME, TGT_BUF_WR, TGT_BUF_RD, TGT_STATUS, TGT_ERROR
   } ucd_tgt_t;

   // One processor bus access.
   typedef struct packed {
      logic        strobe;
      logic        write;
      logic        select;
      logic [15:0] data;
   } ucd_bus_t;

   // One endpoint action toward the endpoint logic.
   typedef struct packed {
      logic       stall;
      logic       unstall;
      logic       validate;
      logic       clear;
      logic       setup_ack;
      logic       status_rd;
      logic [3:0] ep;
   } ucd_ep_cmd_t;

endpackage : ucd_pkg

// [dv/ucd_cpu_model.sv]
// Processor model that issues command and data accesses on the parallel bus.
`timescale 1ns/1ps
module ucd_cpu_model
   import ucd_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Bus toward the decoder
   output ucd_bus_t         bus_out,
   input  wire logic [15:0] rd_data
);
   // The bus starts idle with no strobe.
   initial begin
      bus_out = '0;
   end

   // One access, driven just after an edge and held until the taking edge.
   // Read data is taken at that same edge, before the decoder steps its index.
   // On release the lines show the inverse, so a stale value never matches.
   task automatic access(input logic sel, input logic wr, input logic [15:0] d, output logic [15:0] q);
      @(posedge mclk);
      #1;
      bus_out = '{strobe: 1'b1, write: wr, select: sel, data: d};
      @(posedge mclk);
      q = rd_data;
      #1;
      bus_out = '{strobe: 1'b0, write: ~wr, select: ~sel, data: ~d};
   endtask
endmodule // ucd_cpu_model

// [dv/tb.sv]
// Self-checking testbench for the command decoder driven by a processor model.
`timescale 1ns/1ps
module tb
   import ucd_pkg::*;
;
   logic              mclk;
   logic              srst;
   ucd_bus_t          bus_in;
   logic [15:0]       rd_data;
   logic [NUM_EP-1:0] ep_iso;
   logic [7:0]        ep_status [NUM_EP];
   logic [7:0]        ep_error  [NUM_EP];
   logic [15:0]       frame_number;
   logic [15:0]       buf_rd_data;
   ucd_ep_cmd_t       ep_cmd;
   logic              buf_wr;
   logic              buf_rd;
   logic [3:0]        buf_ep;
   logic [15:0]       buf_wr_data;
   logic [31:0]       irq_enable_reg;
   logic [15:0]       dma_setup_reg;
   logic [15:0]       dma_count_reg;
   logic [15:0]       scratch_reg;
   logic              unlocked;
   logic              dev_reset;
   logic [15:0]       q;
   logic [3:0]        exp_ep;
   int                fail_count = 0;
   int                compares = 0;
   int                wr_cnt = 0;
   int                rd_cnt = 0;

   ucd_decoder ucd_decoder_inst (.mclk(mclk), .srst(srst), .bus_in(bus_in), .rd_data(rd_data), .ep_iso(ep_iso),
      .ep_status(ep_status), .ep_error(ep_error), .frame_number(frame_number), .buf_rd_data(buf_rd_data),
      .ep_cmd(ep_cmd), .buf_wr(buf_wr), .buf_rd(buf_rd), .buf_ep(buf_ep), .buf_wr_data(buf_wr_data),
      .irq_enable_reg(irq_enable_reg), .dma_setup_reg(dma_setup_reg), .dma_count_reg(dma_count_reg),
      .scratch_reg(scratch_reg), .unlocked(unlocked), .dev_reset(dev_reset));

   ucd_cpu_model ucd_cpu_model_inst (.mclk(mclk), .bus_out(bus_in), .rd_data(rd_data));

   // ****************************************************************
   // Clock, checking and bus helpers
   // ****************************************************************
   // Free-running 50 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Compares one value and reports a difference at once.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Command bytes carry a junk upper byte, which the decoder must ignore.
   task automatic cmd(input logic [7:0] c);
      ucd_cpu_model_inst.access(1'b1, 1'b1, {~c, c}, q);
   endtask
   task automatic wr(input logic [15:0] d);
      ucd_cpu_model_inst.access(1'b0, 1'b1, d, q);
   endtask
   task automatic rd(output logic [15:0] d);
      ucd_cpu_model_inst.access(1'b0, 1'b0, 16'hffff, d);
   endtask

   // Counts buffer beats; write data must arrive as an ascending word count.
   always @(posedge mclk) begin
      if (buf_wr === 1'b1) begin
         check("buf_wr_data", buf_wr_data, 32'(wr_cnt));
         check("buf_ep", buf_ep, exp_ep);
         wr_cnt++;
      end
      if (buf_rd === 1'b1) begin
         check("buf_ep", buf_ep, exp_ep);
         rd_cnt++;
      end
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Register writes with a surplus beat, then read back through the odd codes.
   task automatic t_regs();
      logic [7:0]  codes [4];
      logic [31:0] v;
      logic [31:0] seen;
      codes = '{CMD_IRQ_EN_WR, CMD_DMA_SET_WR, CMD_DMA_CNT_WR, CMD_SCRATCH_WR};
      for (int i = 0; i < 4; i++) begin
         v = 32'hc3d2_b1a0 + 32'(i);
         seen = '0;
         cmd(codes[i]);
         wr(v[15:0]);
         if (i == 0) wr(v[31:16]);
         wr(16'hdead);
         cmd(codes[i] | 8'h01);
         rd(seen[15:0]);
         if (i == 0) rd(seen[31:16]);
         check("read_back", seen, (i == 0) ? v : {16'h0000, v[15:0]});
      end
      check("irq_enable_reg", irq_enable_reg, 32'hc3d2_b1a0);
      check("dma_setup_reg", dma_setup_reg, 32'h0000_b1a1);
      check("dma_count_reg", dma_count_reg, 32'h0000_b1a2);
      check("scratch_reg", scratch_reg, 32'h0000_b1a3);
   endtask

   // Immediate endpoint commands, including the two illegal codes.
   task automatic t_ep_cmds();
      logic [3:0] grp [4];
      logic [5:0] f;
      grp = '{GRP_STALL, GRP_UNSTALL, GRP_VALIDATE, GRP_CLEAR};
      for (int g = 0; g < 4; g++) begin
         for (int e = 0; e < 16; e++) begin
            cmd({grp[g], 4'(e)});
            f = {grp[g] == GRP_STALL, grp[g] == GRP_UNSTALL, grp[g] == GRP_VALIDATE && e != 0,
                 grp[g] == GRP_CLEAR && e != 1, 2'b00};
            check("ep_cmd_flags", ep_cmd[9:4], f);
            if (f != 6'h00) check("ep_cmd_ep", ep_cmd.ep, 32'(e));
            @(posedge mclk);
            #1;
            check("ep_cmd_end", ep_cmd[9:4], 32'h0);
         end
      end
      cmd(CMD_SETUP_ACK);
      check("setup_ack", ep_cmd[9:4], 32'h02);
   endtask

   // One-byte status, status copy and error code reads for every endpoint.
   task automatic t_status();
      logic [3:0]  grp [3];
      logic [15:0] d;
      grp = '{GRP_STATUS, GRP_STAT_COPY, GRP_ERROR};
      for (int g = 0; g < 3; g++) begin
         for (int e = 0; e < 16; e++) begin
            cmd({grp[g], 4'(e)});
            check("status_rd", ep_cmd.status_rd, 32'(g == 0));
            rd(d);
            check("byte_read", d, {8'h00, (g == 2) ? ep_error[e] : ep_status[e]});
         end
      end
      cmd(CMD_FRAME_RD);
      rd(d);
      check("frame_number", d, frame_number);
   endtask

   // Buffer write phase: beats beyond the length must be dropped.
   task automatic t_buf_wr(input logic [7:0] c, input int beats, input int exp);
      wr_cnt = 0;
      exp_ep = c[3:0];
      cmd(c);
      for (int i = 0; i < beats; i++) wr(16'(i));
      check("buf_wr_beats", wr_cnt, exp);
   endtask

   // Buffer read phase: data passes through for the defined length only.
   task automatic t_buf_rd(input logic [7:0] c, input int beats, input int exp);
      logic [15:0] d;
      rd_cnt = 0;
      exp_ep = c[3:0];
      cmd(c);
      for (int i = 0; i < beats; i++) begin
         rd(d);
         if (i < exp) check("buf_rd_data", d, buf_rd_data);
         else check("buf_rd_after", d, 32'h0);
      end
      check("buf_rd_beats", rd_cnt, exp);
   endtask

   // Unlock phase: the flag rises only once the write phase is complete.
   task automatic t_unlock();
      cmd(CMD_UNLOCK);
      check("unlocked_early", unlocked, 32'h0);
      wr(16'h00aa);
      check("unlocked", unlocked, 32'h1);
   endtask

   // Device reset command: one pulse, then the registers return to zero.
   task automatic t_dev_reset();
      cmd(CMD_DEV_RESET);
      check("dev_reset", dev_reset, 32'h1);
      @(posedge mclk);
      #1;
      check("dev_reset_end", dev_reset, 32'h0);
      check("irq_enable_clr", irq_enable_reg, 32'h0);
      check("dma_setup_clr", dma_setup_reg, 32'h0);
      check("dma_count_clr", dma_count_reg, 32'h0);
      check("scratch_clr", scratch_reg, 32'h0);
      check("unlocked_clr", unlocked, 32'h0);
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   // Endpoint 2 is isochronous; its odd last byte is left to firmware.
   initial begin
      srst = 1'b1;
      ep_iso = 16'h0004;
      frame_number = 16'h07a5;
      buf_rd_data = 16'h5a3c;
      exp_ep = 4'h0;
      for (int i = 0; i < NUM_EP; i++) begin
         ep_status[i] = 8'(8'h90 + i);
         ep_error[i] = 8'(8'h30 + 3 * i);
      end
      repeat (5) @(posedge mclk);
      #1;
      srst = 1'b0;
      check("unlocked", unlocked, 32'h0);
      t_regs();
      t_unlock();
      t_ep_cmds();
      t_status();
      t_buf_wr(8'h01, 33, 32);
      t_buf_wr(8'h02, 513, 512);
      t_buf_wr(8'h03, 33, 32);
      t_buf_wr(8'h00, 2, 0);
      t_buf_rd(8'h10, 33, 32);
      t_buf_rd(8'h12, 513, 512);
      t_buf_rd(8'h13, 33, 32);
      t_buf_rd(8'h11, 2, 0);
      t_dev_reset();
      final_report();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #(20 * 20000);
      fail_count++;
      final_report();
   end
endmodule // tb
